// [core/irq_ctrl_pkg.sv]
// package: register map, field layout, vectors and carrier types of the interrupt controller
package irq_ctrl_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses on the apb bus)
  // ------------------------------------------------------------
  localparam logic [7:0]  OFS_SENSE1     = 8'h00;
  localparam logic [7:0]  OFS_STATUS     = 8'h04;
  localparam logic [7:0]  OFS_PENDING    = 8'h08;
  localparam logic [5:0]  SENSE1_RESET   = 6'h00;
  localparam int          LINE0_SENSE_LSB = 0;
  localparam int          LINE1_SENSE_LSB = 2;
  localparam int          LINE2_SENSE_LSB = 4;
  localparam int          STAT_MASK_BIT  = 0;
  localparam int          STAT_BUSY_BIT  = 1;
  localparam int          STAT_SEL_LSB   = 4;
  localparam logic        MASK_RESET     = 1'b1;

  // ------------------------------------------------------------
  // sensitivity encodings
  // ------------------------------------------------------------
  localparam logic [1:0]  SENSE_FALL_LOW = 2'h0;
  localparam logic [1:0]  SENSE_RISE     = 2'h1;
  localparam logic [1:0]  SENSE_FALL     = 2'h2;
  localparam logic [1:0]  SENSE_BOTH     = 2'h3;
  localparam logic [1:0]  SENSE_L34      = 2'h0;

  // ------------------------------------------------------------
  // vectors and source indices
  // ------------------------------------------------------------
  localparam int          NUM_VEC   = 14;
  localparam int          NUM_EXT   = 5;
  localparam int          NUM_PER   = 6;
  localparam logic [4:0]  IDX_TRAP  = 5'h0e;
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_TRAP  = 16'hfffc;
  localparam logic [15:0] VEC_TOP   = 16'hfffa;
  localparam logic [13:0] WAKE_HALT_MASK   = 14'h002e;
  localparam logic [13:0] WAKE_AWU_MASK    = 14'h002f;
  localparam logic [13:0] WAKE_ACTIVE_MASK = 14'h0a6e;

  // ------------------------------------------------------------
  // stacking order codes
  // ------------------------------------------------------------
  localparam logic [2:0]  PUSH_PCL = 3'h0;
  localparam logic [2:0]  PUSH_PCH = 3'h1;
  localparam logic [2:0]  PUSH_X   = 3'h2;
  localparam logic [2:0]  PUSH_A   = 3'h3;
  localparam logic [2:0]  PUSH_CC  = 3'h4;

  typedef enum logic [2:0] {PM_RUN, PM_WAIT, PM_HALT, PM_ACTIVE_HALT, PM_AWU_HALT} power_mode_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic       busy;
    logic       pushStrobe;
    logic [2:0] pushSel;
    logic       loadPc;
    logic       fetch;
  } core_ctl_t;

endpackage

// [core/cpu_interrupt_controller.sv]
// interrupt controller: pin sensing, request latches, priority, entry sequence, wakeup
//
// Behaviour
// - maskable requests reach the core only while the global mask is clear.
// - requests arriving while disabled stay latched and get serviced once enabled.
// - after reset the global mask is set, all maskable requests disabled.
// - entry waits instruction end, stacks PC X A CC, sets mask, loads vector, fetches.
// - return instruction restores stacked mask bit and resumes the program.
// - a running handler is not preempted since entry sets the mask.
// - fixed priority: reset, trap, then ascending vector numbers.
// - every source wakes from wait; only chosen ones wake from halt.
// - the trap instruction always enters its service sequence, mask ignored.
// - edge requests latch and clear automatically on entry to their routine.
// - peripheral flag requests need clear mask and enable, else stay pending.
// - peripheral requests clear by writing zero or the flag clearing sequence.
// - the clearing sequence resets the internal latch, dropping pending requests.
// - two-byte vectors descend from reset, trap, vector 0 down to 13.
// - halt exit depends on the source and on the kind of halt.
// - two-bit sense field picks fall+low, rise, fall, or both edges.
// - sense register holds line 2 at 5:4, line 1 at 3:2, line 0 at 1:0.
// - sense register writes take effect only while the global mask is set.
// - the chosen sensitivity applies to that line's request signal.
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module cpu_interrupt_controller
  import irq_ctrl_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire apb_req_t          apbReq,
  output apb_rsp_t               apbRsp,
  input  wire logic [NUM_EXT-1:0] extLine,
  input  wire logic [NUM_PER-1:0] perFlag,
  input  wire logic [NUM_PER-1:0] perEnable,
  input  wire logic [NUM_PER-1:0] perClear,
  input  wire logic              instrDone,
  input  wire logic              trapInstr,
  input  wire logic              iretInstr,
  input  wire logic              stackedMask,
  input  wire logic              maskSet,
  input  wire logic              maskClr,
  input  wire power_mode_t       powerMode,
  output core_ctl_t              coreCtl,
  output logic [15:0]            vectorAddr,
  output logic                   globalMask,
  output logic                   wakeUp
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [4:0] firstSet(input logic [NUM_VEC-1:0] v);
    logic [4:0] r;
    r = 5'h1f;
    for (int i = NUM_VEC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] vecOf(input logic [4:0] idx);
    logic [15:0] r;
    r = VEC_TRAP;
    if (idx != IDX_TRAP) begin
      r = VEC_TOP - {10'h000, idx, 1'b0};
    end
    return r;
  endfunction

  function automatic logic [4:0] extVec(input int i);
    logic [4:0] r;
    r = (i < 3) ? 5'(i + 1) : 5'(i + 2);
    return r;
  endfunction

  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_PUSH_PCL, ST_PUSH_PCH, ST_PUSH_X, ST_PUSH_A, ST_PUSH_CC,
                            ST_LOAD, ST_FETCH} entry_state_t;

  entry_state_t       state;
  entry_state_t       next_state;
  logic [5:0]         sense;
  logic [4:0]         selIdx;
  logic [NUM_VEC-1:0] pend;
  logic               firstCycle;
  logic [31:0]        readData;
  wire                apbSetup  = apbReq.psel && !apbReq.penable;
  wire                apbWrite  = apbReq.psel && apbReq.penable && apbReq.pwrite && apbRsp.pready;
  wire                hitSense  = apbReq.paddr == OFS_SENSE1;
  wire                hitStatus = apbReq.paddr == OFS_STATUS;
  wire                hitPend   = apbReq.paddr == OFS_PENDING;
  wire                mapped    = hitSense || hitStatus || hitPend;
  wire                senseWr   = apbWrite && hitSense && globalMask;

  // reserved bits above the fields read as zero
  always_comb begin
    readData = 32'h0000_0000;
    if (hitSense) begin
      readData[5:0] = sense;
    end else if (hitStatus) begin
      readData[STAT_MASK_BIT] = globalMask;
      readData[STAT_BUSY_BIT] = state != ST_IDLE;
      readData[STAT_SEL_LSB +: 5] = selIdx;
    end else if (hitPend) begin
      readData[NUM_VEC-1:0] = pend;
    end
  end

  // no wait state: pready is high in the first access cycle that follows each setup
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      apbRsp <= '0;
    end else begin
      apbRsp.pready  <= apbSetup;
      apbRsp.pslverr <= apbSetup && !mapped;
      apbRsp.prdata  <= apbSetup ? readData : 32'h0000_0000;
    end
  end

  // a write with the mask clear is accepted on the bus but leaves the field alone
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sense <= SENSE1_RESET;
    end else if (senseWr) begin
      sense <= apbReq.pwdata[5:0];
    end
  end

  // ------------------------------------------------------------
  // external lines
  // ------------------------------------------------------------
  logic [NUM_EXT-1:0] extReq;
  logic [NUM_EXT-1:0] extLatch;
  logic [NUM_EXT-1:0] extHit;
  logic [NUM_EXT-1:0] extClr;
  logic [1:0]         lineMode [NUM_EXT];

  assign lineMode[0] = sense[LINE0_SENSE_LSB +: 2];
  assign lineMode[1] = sense[LINE1_SENSE_LSB +: 2];
  assign lineMode[2] = sense[LINE2_SENSE_LSB +: 2];
  assign lineMode[3] = SENSE_L34;
  assign lineMode[4] = SENSE_L34;

  for (genvar g = 0; g < NUM_EXT; g++) begin : gExt
    logic s1;
    logic s2;
    logic s3;
    logic flt;
    wire  fltNext = (s2 == s3) ? s3 : flt;
    wire  rise    = !flt && fltNext;
    wire  fall    = flt && !fltNext;

    // filtered level resets high so an idle pull-up gives no spurious edge
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        s1  <= 1'b1;
        s2  <= 1'b1;
        s3  <= 1'b1;
        flt <= 1'b1;
      end else begin
        s1  <= extLine[g];
        s2  <= s1;
        s3  <= s2;
        flt <= fltNext;
      end
    end

    assign extHit[g] = (lineMode[g] == SENSE_RISE && rise) ||
                       ((lineMode[g] == SENSE_FALL || lineMode[g] == SENSE_FALL_LOW) && fall) ||
                       (lineMode[g] == SENSE_BOTH && (rise || fall));
    assign extClr[g] = state == ST_LOAD && selIdx == extVec(g);

    // a new edge in the clearing cycle wins
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        extLatch[g] <= 1'b0;
      end else if (extHit[g]) begin
        extLatch[g] <= 1'b1;
      end else if (extClr[g]) begin
        extLatch[g] <= 1'b0;
      end
    end

    assign extReq[g] = extLatch[g] || (lineMode[g] == SENSE_FALL_LOW && !flt);
  end

  // ------------------------------------------------------------
  // peripheral latches
  // ------------------------------------------------------------
  logic [NUM_PER-1:0] perLatch;
  logic [NUM_PER-1:0] perPrev;
  wire  [NUM_PER-1:0] perSet = perFlag & ~perPrev;
  wire  [NUM_PER-1:0] perReq = perLatch & perEnable;

  for (genvar g = 0; g < NUM_PER; g++) begin : gPer
    // the peripheral pulses perClear when its flag is cleared; pending state is dropped
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        perPrev[g]  <= 1'b0;
        perLatch[g] <= 1'b0;
      end else begin
        perPrev[g] <= perFlag[g];
        if (perSet[g]) begin
          perLatch[g] <= 1'b1;
        end else if (perClear[g]) begin
          perLatch[g] <= 1'b0;
        end
      end
    end
  end

  // vectors 4, 12 and 13 have no source
  assign pend = {2'b00, perReq[5], perReq[4], perReq[3], perReq[2], perReq[1],
                 extReq[4], extReq[3], 1'b0, extReq[2], extReq[1], extReq[0], perReq[0]};

  // ------------------------------------------------------------
  // entry sequence
  // ------------------------------------------------------------
  wire takeIrq = (|pend) && !globalMask;
  wire enter   = state == ST_IDLE && instrDone && (trapInstr || takeIrq);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:     next_state = enter ? ST_PUSH_PCL : ST_IDLE;
      ST_PUSH_PCL: next_state = ST_PUSH_PCH;
      ST_PUSH_PCH: next_state = ST_PUSH_X;
      ST_PUSH_X:   next_state = ST_PUSH_A;
      ST_PUSH_A:   next_state = ST_PUSH_CC;
      ST_PUSH_CC:  next_state = ST_LOAD;
      ST_LOAD:     next_state = ST_FETCH;
      ST_FETCH:    next_state = ST_IDLE;
      default:     next_state = ST_IDLE;
    endcase
  end

  core_ctl_t next_coreCtl;

  always_comb begin
    next_coreCtl = '0;
    next_coreCtl.busy = next_state != ST_IDLE;
    case (next_state)
      ST_PUSH_PCL: next_coreCtl.pushSel = PUSH_PCL;
      ST_PUSH_PCH: next_coreCtl.pushSel = PUSH_PCH;
      ST_PUSH_X:   next_coreCtl.pushSel = PUSH_X;
      ST_PUSH_A:   next_coreCtl.pushSel = PUSH_A;
      ST_PUSH_CC:  next_coreCtl.pushSel = PUSH_CC;
      default:     next_coreCtl.pushSel = PUSH_PCL;
    endcase
    next_coreCtl.pushStrobe = next_state inside {ST_PUSH_PCL, ST_PUSH_PCH, ST_PUSH_X, ST_PUSH_A,
                                                 ST_PUSH_CC};
    next_coreCtl.loadPc = next_state == ST_LOAD;
    next_coreCtl.fetch  = next_state == ST_FETCH;
  end

  // the source is frozen at instruction end; later arrivals wait for the next entry
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state      <= ST_IDLE;
      coreCtl    <= '0;
      selIdx     <= IDX_TRAP;
      vectorAddr <= VEC_RESET;
      firstCycle <= 1'b1;
    end else begin
      state      <= next_state;
      coreCtl    <= next_coreCtl;
      firstCycle <= 1'b0;
      if (enter) begin
        selIdx <= trapInstr ? IDX_TRAP : firstSet(pend);
      end
      if (state == ST_PUSH_CC) begin
        vectorAddr <= vecOf(selIdx);
      end
    end
  end

  // entry wins over the core's own mask instructions
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      globalMask <= MASK_RESET;
    end else if (state == ST_PUSH_CC) begin
      globalMask <= 1'b1;
    end else if (state == ST_IDLE && iretInstr) begin
      globalMask <= stackedMask;
    end else if (maskSet) begin
      globalMask <= 1'b1;
    end else if (maskClr) begin
      globalMask <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // low power exit
  // ------------------------------------------------------------
  logic next_wakeUp;

  always_comb begin
    case (powerMode)
      PM_WAIT:        next_wakeUp = |pend;
      PM_HALT:        next_wakeUp = |(pend & WAKE_HALT_MASK);
      PM_AWU_HALT:    next_wakeUp = |(pend & WAKE_AWU_MASK);
      PM_ACTIVE_HALT: next_wakeUp = |(pend & WAKE_ACTIVE_MASK);
      default:        next_wakeUp = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wakeUp <= 1'b0;
    end else begin
      wakeUp <= next_wakeUp;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cbAssert @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_push;
    state == ST_PUSH_PCL ##1 state == ST_PUSH_PCH ##1 state == ST_PUSH_X ##1
    state == ST_PUSH_A ##1 state == ST_PUSH_CC;
  endsequence

  sequence s_load;
    state == ST_LOAD && globalMask ##1 state == ST_FETCH && coreCtl.fetch;
  endsequence

  a_entry_order: assert property (enter |=> s_push ##1 s_load)
    else $error("entry sequence out of order");

  a_mask_gates: assert property (state == ST_IDLE && instrDone && !trapInstr && globalMask
                                 |=> state == ST_IDLE)
    else $error("maskable entry while mask set");

  a_trap_taken: assert property (state == ST_IDLE && instrDone && trapInstr
                                 |=> selIdx == IDX_TRAP ##6 vectorAddr == VEC_TRAP)
    else $error("trap not entered");

  a_reset_masked: assert property (firstCycle |-> globalMask && vectorAddr == VEC_RESET)
    else $error("mask clear after reset");

  a_priority_pick: assert property (enter && !trapInstr |=> selIdx == firstSet($past(pend)))
    else $error("wrong priority choice");

  a_vector_map: assert property (state == ST_PUSH_CC |=> vectorAddr == ((selIdx == IDX_TRAP) ?
                                 VEC_TRAP : VEC_TOP - {10'h000, selIdx, 1'b0}))
    else $error("vector address wrong");

  a_return_from_irq_instr_restore: assert property (state == ST_IDLE && iretInstr
                                   |=> globalMask == $past(stackedMask))
    else $error("mask not restored");

  a_sense_lock: assert property (apbWrite && hitSense && !globalMask |=> $stable(sense))
    else $error("sense written with mask clear");

  a_edge_clear: assert property (extClr[0] && !extHit[0] |=> !extLatch[0])
    else $error("edge request not cleared on entry");

  a_latch_drop: assert property (perClear[0] && !perSet[0] |=> !perLatch[0])
    else $error("peripheral latch kept after clear");

  a_halt_wake: assert property (powerMode == PM_HALT && !(|(pend & WAKE_HALT_MASK))
                                |=> !wakeUp)
    else $error("wrong source woke halt");

endmodule
`default_nettype wire

// [tb/cpu_core_model.sv]
// behavioural core beside the controller: instruction ends, trap requests, stacking check
`timescale 1ns/10ps
`default_nettype none
module cpu_core_model
  import irq_ctrl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        trapReq,
  input  wire core_ctl_t   coreCtl,
  input  wire logic [15:0] vectorAddr,
  output logic             instrDone,
  output logic             trapInstr,
  output int               entries,
  output logic [15:0]      lastVec,
  output int               pushErr
);
  // ------------------------------------------------------------
  // instruction pacing and entry bookkeeping
  // ------------------------------------------------------------
  logic [1:0] phase;
  logic [2:0] expSel;

  // an instruction ends every fourth cycle; none ends while stacking runs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase     <= 2'h0;
      instrDone <= 1'b0;
      trapInstr <= 1'b0;
      entries   <= 0;
      lastVec   <= 16'h0000;
      pushErr   <= 0;
      expSel    <= PUSH_PCL;
    end else begin
      phase     <= phase + 2'h1;
      instrDone <= (phase == 2'h3) && !coreCtl.busy;
      trapInstr <= (phase == 2'h3) && !coreCtl.busy && trapReq;
      if (coreCtl.pushStrobe) begin
        if (coreCtl.pushSel !== expSel) pushErr <= pushErr + 1;
        expSel <= expSel + 3'h1;
      end
      if (coreCtl.loadPc) begin
        if (expSel !== 3'h5) pushErr <= pushErr + 1;
        entries <= entries + 1;
        lastVec <= vectorAddr;
        expSel  <= PUSH_PCL;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the interrupt controller
`timescale 1ns/10ps
`default_nettype none
module tb;
  import irq_ctrl_pkg::*;
  logic        clk;
  logic        arst_n;
  apb_req_t    req;
  apb_rsp_t    rsp;
  logic [4:0]  ext;
  logic [5:0]  pf;
  logic [5:0]  pe;
  logic [5:0]  pc;
  logic        return_from_irq_instr;
  logic        stk;
  logic        mset;
  logic        mclr;
  logic        trapReq;
  logic        instrDone;
  logic        trapInstr;
  power_mode_t pm;
  core_ctl_t   ctl;
  logic [15:0] vec;
  logic [15:0] lastVec;
  logic        gmask;
  logic        wake;
  logic [31:0] rd;
  logic        err;
  logic [1:0]  md;
  int          entries;
  int          pushErr;
  int          n_fail;
  int          checked;
  int          cyc;
  int          e0;

  cpu_interrupt_controller i_cpu_interrupt_controller (
    .clk(clk), .arst_n(arst_n), .apbReq(req), .apbRsp(rsp), .extLine(ext), .perFlag(pf),
    .perEnable(pe), .perClear(pc), .instrDone(instrDone), .trapInstr(trapInstr),
    .iretInstr(return_from_irq_instr), .stackedMask(stk), .maskSet(mset), .maskClr(mclr), .powerMode(pm),
    .coreCtl(ctl), .vectorAddr(vec), .globalMask(gmask), .wakeUp(wake));

  cpu_core_model i_cpu_core_model (
    .clk(clk), .arst_n(arst_n), .trapReq(trapReq), .coreCtl(ctl), .vectorAddr(vec),
    .instrDone(instrDone), .trapInstr(trapInstr), .entries(entries), .lastVec(lastVec),
    .pushErr(pushErr));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // no cycle count is assumed: the access phase lasts until pready, the timeout ends a hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    // one idle edge so a following call never drives req twice in one time step
    @(posedge clk);
  endtask

  task automatic pend(input int idx, input logic e);
    apb(1'b0, OFS_PENDING, 32'h0);
    check(rd[idx], e);
  endtask

  // clear the mask, give the core time to enter, then mask again
  task automatic service(input logic hit, input logic [15:0] expVec);
    e0 = entries;
    mclr <= 1'b1;
    @(posedge clk);
    mclr <= 1'b0;
    tick(30);
    check(entries - e0, hit);
    if (hit) check(lastVec, expVec);
    check(gmask, hit);
    mset <= 1'b1;
    @(posedge clk);
    mset <= 1'b0;
    tick(2);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // a hang counts as a mismatch and closes the run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    req = '0;
    ext = 5'h1f;
    pf = 6'h00;
    pe = 6'h00;
    pc = 6'h00;
    {return_from_irq_instr, stk, mset, mclr, trapReq} = 5'h00;
    pm = PM_RUN;
    tick(2);
    arst_n <= 1'b1;
    @(posedge clk);
    check(gmask, 1'b1);
    check(vec, VEC_RESET);
    apb(1'b0, OFS_SENSE1, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    apb(1'b1, OFS_SENSE1, 32'hff);
    apb(1'b0, OFS_SENSE1, 32'h0);
    check(rd, 32'h3f);
    mclr <= 1'b1;
    @(posedge clk);
    mclr <= 1'b0;
    tick(2);
    apb(1'b1, OFS_SENSE1, 32'h0);
    apb(1'b0, OFS_SENSE1, 32'h0);
    check(rd, 32'h3f);
    // trap with the mask clear, then return with a clear stacked mask
    e0 = entries;
    trapReq <= 1'b1;
    for (int i = 0; i < 40 && entries == e0; i++) @(posedge clk);
    trapReq <= 1'b0;
    check(lastVec, VEC_TRAP);
    tick(6);
    // status: mask set, idle, trap index selected; writes there are ignored without error
    apb(1'b1, OFS_STATUS, 32'h0);
    check(err, 1'b0);
    apb(1'b0, OFS_STATUS, 32'h0);
    check(rd, 32'h0000_00e1);
    check(err, 1'b0);
    return_from_irq_instr <= 1'b1;
    @(posedge clk);
    return_from_irq_instr <= 1'b0;
    tick(2);
    check(gmask, 1'b0);
    mset <= 1'b1;
    @(posedge clk);
    mset <= 1'b0;
    tick(2);
    // every sensitivity mode on line 2, falling then rising
    for (int m = 0; m < 4; m++) begin
      md = m[1:0];
      apb(1'b1, OFS_SENSE1, {26'h0, md, 4'h0});
      ext[2] <= 1'b0;
      tick(8);
      pend(3, md != 2'h1);
      service(md != 2'h1, 16'hfff4);
      pend(3, md == 2'h0);
      ext[2] <= 1'b1;
      tick(8);
      pend(3, md[0]);
      service(md[0], 16'hfff4);
    end
    // wakeup source against ext line 1: lower vector number wins
    apb(1'b1, OFS_SENSE1, 32'h08);
    pe <= 6'h01;
    pf[0] <= 1'b1;
    ext[1] <= 1'b0;
    tick(8);
    pend(2, 1'b1);
    service(1'b1, VEC_TOP);
    pc[0] <= 1'b1;
    @(posedge clk);
    pc <= 6'h00;
    tick(2);
    pend(0, 1'b0);
    service(1'b1, 16'hfff6);
    ext[1] <= 1'b1;
    pf[0] <= 1'b0;
    pe <= 6'h00;
    // voltage detector: disabled, discarded by clearing, then enabled
    pf[1] <= 1'b1;
    tick(4);
    pend(7, 1'b0);
    service(1'b0, 16'h0);
    pc[1] <= 1'b1;
    @(posedge clk);
    pc <= 6'h00;
    pe[1] <= 1'b1;
    tick(4);
    service(1'b0, 16'h0);
    pf[1] <= 1'b0;
    tick(2);
    pf[1] <= 1'b1;
    pm <= PM_HALT;
    tick(4);
    check(wake, 1'b0);
    pm <= PM_WAIT;
    tick(4);
    check(wake, 1'b1);
    pm <= PM_RUN;
    service(1'b1, 16'hffec);
    pc[1] <= 1'b1;
    @(posedge clk);
    pc <= 6'h00;
    pf[1] <= 1'b0;
    pe <= 6'h00;
    // external line 0 low level wakes from halt
    pm <= PM_HALT;
    ext[0] <= 1'b0;
    tick(8);
    check(wake, 1'b1);
    pm <= PM_RUN;
    ext[0] <= 1'b1;
    service(1'b1, 16'hfff8);
    check(pushErr, 0);
    summarize();
  end
endmodule
`default_nettype wire
